// file: hdl/handler_pkg.sv
// Shared constants and types for the handler sequencer and result talker
package handler_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] OUTSEL_OFFSET = 8'h04;
   localparam logic [7:0] NOMINAL_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0c;
   localparam logic [7:0] PANEL_OFFSET = 8'h10;
   // Control register fields
   localparam int CTRL_ENTER_BIT = 0;
   localparam int CTRL_TRIGGERED_BIT = 1;
   localparam int CTRL_FULL_OPTION_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h2;
   localparam logic [3:0] OUTSEL_RESET = 4'h0;
   localparam logic [31:0] NOMINAL_RESET = 32'h00000000;
   // Status register fields
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_PASS_BIT = 1;
   localparam int STATUS_TALKER_IDLE_BIT = 2;
   localparam int STATUS_BIN_LSB = 4;
   // Panel register fields
   localparam int PANEL_START_BIT = 0;
   // Output selection
   localparam logic [3:0] CODE_FAIL_ONLY = 4'h8;
   localparam logic [3:0] CODE_BIN_ON_PASS = 4'h9;
   localparam logic [2:0] MASK_BIN = 3'h1;
   localparam logic [2:0] MASK_FULL = 3'h7;
   // String lengths including CR and LF
   localparam int PRIMARY_LEN = 17;
   localparam int SECONDARY_LEN = 17;
   localparam int BIN_LEN = 10;
   // Handler bin outputs
   localparam int BIN_COUNT = 15;
   localparam logic [3:0] REDUCED_FIRST = 4'h9;
   localparam logic [3:0] REDUCED_LAST = 4'hd;
   localparam logic [3:0] LUMP_BIN = 4'he;
   // Data settling time before the data-valid line is raised
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETTLE_NS = 100;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [2:0] {ST_IDLE, ST_ACQUIRE, ST_CALC, ST_SEND, ST_DRAIN} seq_state_t;
   typedef enum logic [2:0] {TK_IDLE, TK_SETTLE, TK_READY, TK_ACCEPT, TK_RELEASE} talk_state_t;
endpackage

// file: hdl/byte_stream_if.sv
// Valid/ready character stream between the sequencer, FIFO and talker
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: hdl/char_fifo.sv
// Character FIFO with valid/ready on both sides
`timescale 1ns/1ps
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   byte_stream_if.snk fill,
   byte_stream_if.src drain,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_reg;
   logic [AW:0] rdPtr_reg;
   wire full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
   wire push = fill.valid && !full;
   wire pop = drain.ready && !empty;
   assign empty = (wrPtr_reg == rdPtr_reg);
   assign fill.ready = !full;
   assign drain.valid = !empty;
   assign drain.data = mem[rdPtr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg[AW-1:0]] <= fill.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
      end
   end
endmodule

// file: hdl/source_handshake.sv
// Talk-only source handshake: data lines, data-valid, and listener ready/accept inputs
`timescale 1ns/1ps
module source_handshake (
   input wire logic clk,
   input wire logic rst_n,
   byte_stream_if.snk chars,
   input wire logic notReadyPin,
   input wire logic notAcceptedPin,
   output logic [7:0] busData,
   output logic busDataOe,
   output logic busDav,
   output logic busDavOe,
   output logic idle
);
   handler_pkg::talk_state_t state_reg, state_next;
   logic [2:0] nrfdSync_reg;
   logic [2:0] ndacSync_reg;
   logic nrfd_reg;
   logic ndac_reg;
   logic [7:0] data_reg;
   logic [7:0] settle_reg;

   wire take = (state_reg == handler_pkg::TK_IDLE) && chars.valid;
   wire settled = (settle_reg == 8'(handler_pkg::SETTLE_CYCLES - 1));
   assign chars.ready = (state_reg == handler_pkg::TK_IDLE);
   assign idle = (state_reg == handler_pkg::TK_IDLE);
   assign busData = data_reg;
   assign busDataOe = (state_reg != handler_pkg::TK_IDLE);
   // Sole talker: data-valid is always driven
   assign busDavOe = 1'b1;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         handler_pkg::TK_IDLE: if (chars.valid) state_next = handler_pkg::TK_SETTLE;
         handler_pkg::TK_SETTLE: if (settled) state_next = handler_pkg::TK_READY;
         handler_pkg::TK_READY: if (!nrfd_reg) state_next = handler_pkg::TK_ACCEPT;
         handler_pkg::TK_ACCEPT: if (!ndac_reg) state_next = handler_pkg::TK_RELEASE;
         handler_pkg::TK_RELEASE: if (ndac_reg) state_next = handler_pkg::TK_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= handler_pkg::TK_IDLE;
         busDav <= 1'b0;
      end else begin
         state_reg <= state_next;
         busDav <= (state_next == handler_pkg::TK_ACCEPT);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= 8'h00;
         settle_reg <= 8'h00;
      end else begin
         if (take) begin
            data_reg <= chars.data;
         end
         settle_reg <= (state_reg == handler_pkg::TK_SETTLE) ? settle_reg + 8'h01 : 8'h00;
      end
   end

   // Pins are high while a listener asserts not-ready or not-accepted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nrfdSync_reg <= 3'h7;
         ndacSync_reg <= 3'h7;
         nrfd_reg <= 1'b1;
         ndac_reg <= 1'b1;
      end else begin
         nrfdSync_reg <= {nrfdSync_reg[1:0], notReadyPin};
         ndacSync_reg <= {ndacSync_reg[1:0], notAcceptedPin};
         if (nrfdSync_reg[1] == nrfdSync_reg[2]) begin
            nrfd_reg <= nrfdSync_reg[2];
         end
         if (ndacSync_reg[1] == ndacSync_reg[2]) begin
            ndac_reg <= ndacSync_reg[2];
         end
      end
   end
endmodule

// file: hdl/handler_sync_and_result_output.sv
// Handler sequencing, bin outputs, APB registers and result string output
//
// What this block does
// - Pulse end-of-test once bin is decided
// - Pulse acquisition-done before calculation ends
// - Triggered mode starts only on start input or a panel start write
// - Zero nominal suppresses end-of-test and lamps
// - Reduced card lumps bins nine-thirteen into fourteen
// - Selection code picks which strings go out
// - Selection code changes only in enter function
// - Send selected strings after each measurement
// - Strings are 17, 17 and 10 characters
// - Slowest listener throttles the measurement rate
`timescale 1ns/1ps
module handler_sync_and_result_output #(
   parameter int PRIMARY_CHARS = handler_pkg::PRIMARY_LEN,
   parameter int SECONDARY_CHARS = handler_pkg::SECONDARY_LEN,
   parameter int BIN_CHARS = handler_pkg::BIN_LEN,
   parameter int FIFO_WORDS = handler_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic startPin,
   output logic measStart,
   input wire logic acqDoneIn,
   input wire logic calcDoneIn,
   input wire logic passIn,
   input wire logic [3:0] binIn,
   input wire logic [8*PRIMARY_CHARS-1:0] primaryText,
   input wire logic [8*SECONDARY_CHARS-1:0] secondaryText,
   input wire logic [8*BIN_CHARS-1:0] binText,
   output logic acquisitionDoneStrobe,
   output logic endOfTestStrobe,
   output logic passLamp,
   output logic failLamp,
   output logic [handler_pkg::BIN_COUNT-1:0] handlerBins,
   output logic [7:0] busData,
   output logic busDataOe,
   output logic busDav,
   output logic busDavOe,
   input wire logic notReadyPin,
   input wire logic notAcceptedPin
);
   handler_pkg::seq_state_t state_reg, state_next;
   logic [2:0] ctrl_reg;
   logic [3:0] outSel_reg;
   logic [31:0] nominal_reg;
   logic panelStart_reg;
   logic [2:0] startSync_reg;
   logic startFilt_reg;
   logic startPrev_reg;
   logic lastPass_reg;
   logic [3:0] lastBin_reg;
   logic [2:0] mask_reg;
   logic [1:0] seg_reg;
   logic [4:0] idx_reg;
   logic [8*PRIMARY_CHARS-1:0] primary_reg;
   logic [8*SECONDARY_CHARS-1:0] secondary_reg;
   logic [8*BIN_CHARS-1:0] binStr_reg;
   logic fifoEmpty;
   logic talkerIdle;
   logic [31:0] statusWord;

   byte_stream_if #(.WIDTH(8)) toFifo ();
   byte_stream_if #(.WIDTH(8)) toTalker ();

   // Length of a result string by segment: 0 primary, 1 secondary, 2 bin
   function automatic logic [4:0] segLen(input logic [1:0] seg);
      logic [4:0] len;
      len = 5'(BIN_CHARS);
      if (seg == 2'd0) begin
         len = 5'(PRIMARY_CHARS);
      end else if (seg == 2'd1) begin
         len = 5'(SECONDARY_CHARS);
      end
      return len;
   endfunction

   // First enabled segment at or after the given one; 3 means none left
   function automatic logic [1:0] findSeg(input logic [2:0] mask, input logic [2:0] from);
      logic [1:0] found;
      found = 2'd3;
      for (int i = 2; i >= 0; i--) begin
         if ((3'(i) >= from) && mask[2-i]) begin
            found = 2'(i);
         end
      end
      return found;
   endfunction

   // Register access decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire hitCtrl = (paddr == handler_pkg::CTRL_OFFSET);
   wire hitOutSel = (paddr == handler_pkg::OUTSEL_OFFSET);
   wire hitNominal = (paddr == handler_pkg::NOMINAL_OFFSET);
   wire hitStatus = (paddr == handler_pkg::STATUS_OFFSET);
   wire hitPanel = (paddr == handler_pkg::PANEL_OFFSET);
   wire mapped = hitCtrl || hitOutSel || hitNominal || hitStatus || hitPanel;
   wire wrEn = access && pwrite && mapped;
   wire enterFunc = ctrl_reg[handler_pkg::CTRL_ENTER_BIT];
   wire triggered = ctrl_reg[handler_pkg::CTRL_TRIGGERED_BIT];
   wire fullOption = ctrl_reg[handler_pkg::CTRL_FULL_OPTION_BIT];
   // Codes above nine leave the old selection in place
   wire codeLegal = (pwdata[31:4] == 28'h0000000) &&
                    (pwdata[3:0] <= handler_pkg::CODE_BIN_ON_PASS);
   wire outSelWrite = wrEn && hitOutSel && enterFunc && codeLegal;
   wire panelWrite = wrEn && hitPanel && pwdata[handler_pkg::PANEL_START_BIT];
   wire nominalZero = (nominal_reg == 32'h00000000);

   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // Status fields sit at their package positions
   always_comb begin
      statusWord = 32'h00000000;
      statusWord[handler_pkg::STATUS_BUSY_BIT] = (state_reg != handler_pkg::ST_IDLE);
      statusWord[handler_pkg::STATUS_PASS_BIT] = lastPass_reg;
      statusWord[handler_pkg::STATUS_TALKER_IDLE_BIT] = talkerIdle;
      statusWord[handler_pkg::STATUS_BIN_LSB +: 4] = lastBin_reg;
   end
   wire [31:0] readMux = hitCtrl ? {29'h00000000, ctrl_reg} :
                         hitOutSel ? {28'h0000000, outSel_reg} :
                         hitNominal ? nominal_reg :
                         hitStatus ? statusWord : 32'h00000000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata <= readMux;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= handler_pkg::CTRL_RESET;
         outSel_reg <= handler_pkg::OUTSEL_RESET;
         nominal_reg <= handler_pkg::NOMINAL_RESET;
         panelStart_reg <= 1'b0;
      end else begin
         if (wrEn && hitCtrl) begin
            ctrl_reg <= pwdata[2:0];
         end
         if (outSelWrite) begin
            outSel_reg <= pwdata[3:0];
         end
         if (wrEn && hitNominal) begin
            nominal_reg <= pwdata;
         end
         panelStart_reg <= panelWrite;
      end
   end

   // Start pin through three flops; a change counts when the last two agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         startSync_reg <= 3'h0;
         startFilt_reg <= 1'b0;
         startPrev_reg <= 1'b0;
      end else begin
         startSync_reg <= {startSync_reg[1:0], startPin};
         if (startSync_reg[1] == startSync_reg[2]) begin
            startFilt_reg <= startSync_reg[2];
         end
         startPrev_reg <= startFilt_reg;
      end
   end

   wire startEdge = startFilt_reg && !startPrev_reg;
   wire startReq = triggered ? (startEdge || panelStart_reg) : 1'b1;
   // A start while busy is dropped, not queued
   wire go = (state_reg == handler_pkg::ST_IDLE) && !enterFunc && startReq;

   wire [2:0] calcMask = (outSel_reg == handler_pkg::CODE_FAIL_ONLY) ?
                            (passIn ? 3'h0 : handler_pkg::MASK_FULL) :
                         (outSel_reg == handler_pkg::CODE_BIN_ON_PASS) ?
                            (passIn ? handler_pkg::MASK_BIN : handler_pkg::MASK_FULL) :
                         outSel_reg[2:0];
   wire [1:0] firstSeg = findSeg(calcMask, 3'd0);
   wire [4:0] curLen = segLen(seg_reg);
   wire lastChar = (idx_reg == curLen - 5'd1);
   wire [1:0] afterSeg = findSeg(mask_reg, 3'(seg_reg) + 3'd1);
   wire push = (state_reg == handler_pkg::ST_SEND) && toFifo.ready;

   // first character in the top byte
   wire [7:0] primaryChar = primary_reg[8*(PRIMARY_CHARS-1-int'(idx_reg)) +: 8];
   wire [7:0] secondaryChar = secondary_reg[8*(SECONDARY_CHARS-1-int'(idx_reg)) +: 8];
   wire [7:0] binChar = binStr_reg[8*(BIN_CHARS-1-int'(idx_reg)) +: 8];

   assign toFifo.valid = (state_reg == handler_pkg::ST_SEND);
   assign toFifo.data = (seg_reg == 2'd0) ? primaryChar :
                        (seg_reg == 2'd1) ? secondaryChar : binChar;
   assign measStart = go;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         handler_pkg::ST_IDLE: if (go) state_next = handler_pkg::ST_ACQUIRE;
         handler_pkg::ST_ACQUIRE: if (acqDoneIn) state_next = handler_pkg::ST_CALC;
         handler_pkg::ST_CALC: begin
            if (calcDoneIn) begin
               state_next = (calcMask == 3'h0) ? handler_pkg::ST_IDLE : handler_pkg::ST_SEND;
            end
         end
         handler_pkg::ST_SEND: begin
            if (push && lastChar && (afterSeg == 2'd3)) begin
               state_next = handler_pkg::ST_DRAIN;
            end
         end
         handler_pkg::ST_DRAIN: begin
            if (fifoEmpty && talkerIdle) begin
               state_next = handler_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= handler_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Pass flag, bin and strings are valid only with calcDoneIn
   wire calcEnd = (state_reg == handler_pkg::ST_CALC) && calcDoneIn;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acquisitionDoneStrobe <= 1'b0;
      end else begin
         acquisitionDoneStrobe <= (state_reg == handler_pkg::ST_ACQUIRE) && acqDoneIn;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         endOfTestStrobe <= 1'b0;
      end else begin
         endOfTestStrobe <= calcEnd && !nominalZero;
      end
   end

   wire lumped = !fullOption && (binIn >= handler_pkg::REDUCED_FIRST) &&
                 (binIn <= handler_pkg::REDUCED_LAST);
   wire [3:0] outBin = lumped ? handler_pkg::LUMP_BIN : binIn;
   // Bin numbers past the last output light nothing
   wire binInRange = (int'(outBin) < handler_pkg::BIN_COUNT);
   wire [handler_pkg::BIN_COUNT-1:0] binOneHot = binInRange ?
      (handler_pkg::BIN_COUNT)'(1) << outBin : '0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         handlerBins <= '0;
         passLamp <= 1'b0;
         failLamp <= 1'b0;
         lastPass_reg <= 1'b0;
         lastBin_reg <= 4'h0;
      end else if (go) begin
         handlerBins <= '0;
         passLamp <= 1'b0;
         failLamp <= 1'b0;
      end else if (calcEnd) begin
         handlerBins <= binOneHot;
         passLamp <= passIn && !nominalZero;
         failLamp <= !passIn && !nominalZero;
         lastPass_reg <= passIn;
         lastBin_reg <= outBin;
      end
   end

   // Latch result strings and walk them character by character
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         primary_reg <= '0;
         secondary_reg <= '0;
         binStr_reg <= '0;
         mask_reg <= 3'h0;
         seg_reg <= 2'd0;
         idx_reg <= 5'd0;
      end else if (calcEnd) begin
         primary_reg <= primaryText;
         secondary_reg <= secondaryText;
         binStr_reg <= binText;
         mask_reg <= calcMask;
         seg_reg <= firstSeg;
         idx_reg <= 5'd0;
      end else if (push) begin
         if (lastChar) begin
            seg_reg <= afterSeg;
            idx_reg <= 5'd0;
         end else begin
            idx_reg <= idx_reg + 5'd1;
         end
      end
   end

   char_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) fifo (
      .clk(clk),
      .rst_n(rst_n),
      .fill(toFifo),
      .drain(toTalker),
      .empty(fifoEmpty)
   );

   source_handshake talker (
      .clk(clk),
      .rst_n(rst_n),
      .chars(toTalker),
      .notReadyPin(notReadyPin),
      .notAcceptedPin(notAcceptedPin),
      .busData(busData),
      .busDataOe(busDataOe),
      .busDav(busDav),
      .busDavOe(busDavOe),
      .idle(talkerIdle)
   );
endmodule

// file: verification/handler_sync_chk.sv
// Concurrent checks on the handler sequencer ports
`timescale 1ns/1ps
module handler_sync_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic measStart,
   input wire logic acqDoneIn,
   input wire logic calcDoneIn,
   input wire logic passIn,
   input wire logic acquisitionDoneStrobe,
   input wire logic endOfTestStrobe,
   input wire logic passLamp,
   input wire logic failLamp,
   input wire logic [handler_pkg::BIN_COUNT-1:0] handlerBins,
   input wire logic [7:0] busData,
   input wire logic busDataOe,
   input wire logic busDav,
   input wire logic notReadyPin,
   input wire logic notAcceptedPin
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_acq_strobe_cause: assert property (
      acquisitionDoneStrobe |-> $past(acqDoneIn) ##1 !acquisitionDoneStrobe)
      else $error("acquisition strobe without cause");
   a_eot_strobe_cause: assert property (
      endOfTestStrobe |-> $past(calcDoneIn) ##1 !endOfTestStrobe)
      else $error("end of test strobe without cause");
   a_pass_lamp_cause: assert property (
      $rose(passLamp) |-> $past(calcDoneIn) && $past(passIn))
      else $error("pass lamp without passing result");
   a_fail_lamp_cause: assert property (
      $rose(failLamp) |-> $past(calcDoneIn) && !$past(passIn))
      else $error("fail lamp without failing result");
   a_start_clears_out: assert property (
      measStart |=> !passLamp && !failLamp && handlerBins == '0)
      else $error("outputs not cleared at start");
   a_start_single: assert property (measStart |=> !measStart)
      else $error("start longer than one cycle");
   a_bins_one_hot: assert property ($onehot0(handlerBins))
      else $error("more than one bin output");
   a_dav_needs_ready: assert property (
      $rose(busDav) |-> !notReadyPin && !$past(notReadyPin, 2))
      else $error("data valid raised while listener not ready");
   a_dav_needs_accept: assert property (
      $fell(busDav) |-> !$past(notAcceptedPin, 2))
      else $error("data valid dropped before acceptance");
   a_data_held: assert property (busDav |-> busDataOe && $stable(busData))
      else $error("character changed while valid");
   c_eot: cover property (endOfTestStrobe);
   c_char: cover property ($rose(busDav));
   c_fail: cover property ($rose(failLamp));
endmodule

bind handler_sync_and_result_output handler_sync_chk chk (.*);

// file: verification/listener_model.sv
// Behavioural listen-only devices on the talk-only bus
`timescale 1ns/1ps
module listener_model (
   input wire logic clk,
   input wire logic [7:0] busData,
   input wire logic busDav,
   input wire logic [7:0] lag,
   output logic notReadyPin,
   output logic notAcceptedPin
);
   logic [7:0] got[$];
   initial begin
      notReadyPin = 1'b0;
      notAcceptedPin = 1'b1;
      forever begin
         @(posedge clk);
         if (busDav === 1'b1) begin
            notReadyPin <= 1'b1;
            repeat (lag) @(posedge clk);
            got.push_back(busData);
            notAcceptedPin <= 1'b0;
            while (busDav !== 1'b0) @(posedge clk);
            notAcceptedPin <= 1'b1;
            repeat (lag) @(posedge clk);
            notReadyPin <= 1'b0;
         end
      end
   end
endmodule

// file: verification/tb_top.sv
// Testbench for the handler sequencer and talk-only result output
`timescale 1ns/1ps
module tb_top;
   localparam logic [135:0] PRIM = {"PRIMARY-VALUE-1", 8'h0d, 8'h0a};
   localparam logic [135:0] SEC = {"SECOND-VALUE-22", 8'h0d, 8'h0a};
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, startPin, measStart;
   logic acqDoneIn, calcDoneIn, passIn, acquisitionDoneStrobe, endOfTestStrobe;
   logic passLamp, failLamp, busDataOe, busDav, busDavOe, notReadyPin, notAcceptedPin;
   logic [7:0] paddr, busData, lag;
   logic [31:0] pwdata, prdata, rdData;
   logic [3:0] binIn;
   logic [79:0] binText;
   logic [14:0] handlerBins;
   logic apbErr;
   int failures = 0;
   int n_compared = 0;
   int starts = 0;
   int idleStarts;
   logic [7:0] expQ[$];
   handler_sync_and_result_output DUT (.primaryText(PRIM), .secondaryText(SEC), .*);
   listener_model lst (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (measStart === 1'b1) starts <= starts + 1;
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdData = prdata;
      apbErr = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", e, rdData);
   endtask
   task automatic push_text(input logic [135:0] t, input int len);
      for (int k = len - 1; k >= 0; k--) begin
         expQ.push_back(t[8*k +: 8]);
      end
   endtask
   task automatic run_meas(input int code, input logic pass, input logic [3:0] bin,
                           input logic full, input logic panel, input logic nomZero);
      int s0;
      int n;
      logic [3:0] eb;
      logic [2:0] mask;
      eb = (!full && bin >= 4'h9 && bin <= 4'hd) ? 4'he : bin;
      mask = code < 8 ? code[2:0] : (!pass ? 3'h7 : (code == 9 ? 3'h1 : 3'h0));
      s0 = starts;
      lst.got.delete();
      if (panel) wr(handler_pkg::PANEL_OFFSET, 32'h1);
      else startPin <= 1'b1;
      n = 0;
      while (starts == s0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("start", s0 + 1, starts);
      startPin <= 1'b0;
      {passIn, binIn} <= {pass, bin};
      binText <= {"BIN-NO-", 8'h41 + {4'h0, bin}, 8'h0d, 8'h0a};
      repeat (2) @(posedge clk);
      acqDoneIn <= 1'b1;
      @(posedge clk);
      acqDoneIn <= 1'b0;
      #1 chk("acq strobe", 1, acquisitionDoneStrobe);
      @(posedge clk);
      calcDoneIn <= 1'b1;
      @(posedge clk);
      calcDoneIn <= 1'b0;
      #1 chk("eot strobe", !nomZero, endOfTestStrobe);
      chk("lamps", nomZero ? 2'b00 : {pass, !pass}, {passLamp, failLamp});
      chk("bins", 15'h1 << eb, handlerBins);
      @(posedge clk);
      n = 0;
      do begin
         apb(1'b0, handler_pkg::STATUS_OFFSET, 32'h0);
         n++;
      end while (rdData[handler_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 4000);
      chk("status", {24'h0, eb, 2'b01, pass, 1'b0}, rdData);
      expQ.delete();
      if (mask[2]) push_text(PRIM, 17);
      if (mask[1]) push_text(SEC, 17);
      if (mask[0]) push_text({56'h0, binText}, 10);
      chk("char count", expQ.size(), lst.got.size());
      foreach (expQ[k]) chk("char", expQ[k], lst.got[k]);
      $display("test code %0d pass %0b done", code, pass);
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("BAD watchdog expected finish seen hang");
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, startPin, acqDoneIn, calcDoneIn, passIn} = 7'h00;
      {paddr, pwdata, binIn, binText} = '0;
      lag = 8'h01;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(handler_pkg::CTRL_OFFSET, 32'h2);
      rd_chk(handler_pkg::OUTSEL_OFFSET, 32'h0);
      rd_chk(handler_pkg::NOMINAL_OFFSET, 32'h0);
      rd_chk(handler_pkg::PANEL_OFFSET, 32'h0);
      chk("dav enable", 1, busDavOe);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 1, apbErr);
      wr(handler_pkg::OUTSEL_OFFSET, 32'h7);
      rd_chk(handler_pkg::OUTSEL_OFFSET, 32'h0);
      wr(handler_pkg::CTRL_OFFSET, 32'h3);
      wr(handler_pkg::OUTSEL_OFFSET, 32'ha);
      rd_chk(handler_pkg::OUTSEL_OFFSET, 32'h0);
      wr(handler_pkg::CTRL_OFFSET, 32'h2);
      $display("test registers done");
      run_meas(0, 1'b1, 4'ha, 1'b0, 1'b0, 1'b1);
      idleStarts = starts;
      repeat (60) @(posedge clk);
      chk("no start", idleStarts, starts);
      wr(handler_pkg::NOMINAL_OFFSET, 32'h5);
      for (int i = 0; i < 12; i++) begin
         lag <= (i == 6) ? 8'h14 : 8'h01;
         wr(handler_pkg::CTRL_OFFSET, {29'h0, i[0], 2'b11});
         wr(handler_pkg::OUTSEL_OFFSET, i < 10 ? i : i - 2);
         wr(handler_pkg::CTRL_OFFSET, {29'h0, i[0], 2'b10});
         run_meas(i < 10 ? i : i - 2, i < 10, 4'(i + 3), i[0], i == 4, 1'b0);
      end
      idleStarts = starts;
      wr(handler_pkg::CTRL_OFFSET, 32'h0);
      repeat (2) @(posedge clk);
      chk("free start", idleStarts + 1, starts);
      $display("test free run done");
      final_report();
   end
endmodule
